/* File: include/smc_regs.svh */
// register addresses, field positions, reset values and timing for sync and mode control
`ifndef SMC_REGS_SVH
`define SMC_REGS_SVH

`define SMC_WORD_W          32
`define SMC_ADDR_W          5
`define SMC_ADDR_FB_DIV     5'h0a
`define SMC_ADDR_MODE_SYNC  5'h0b
`define SMC_ADDR_DLY_LAST   5'h05

`define SMC_FB_SEL_HI       7
`define SMC_FB_SEL_LO       5
`define SMC_FB_EXT          3'h6

`define SMC_MODE_HI         31
`define SMC_MODE_LO         27
`define SMC_EN_SYNC         26
`define SMC_EXCL_HI         25
`define SMC_EXCL_LO         20
`define SMC_PIN_SEL_HI      19
`define SMC_PIN_SEL_LO      18
`define SMC_QUAL            17
`define SMC_POL             16
`define SMC_AUTO            15
`define SMC_TYPE_HI         14
`define SMC_TYPE_LO         12
`define SMC_XTAL_EN         5

`define SMC_MODE_DUAL_INT    5'h00
`define SMC_MODE_DUAL_INT_ZD 5'h02
`define SMC_MODE_DUAL_EXT    5'h03
`define SMC_MODE_DUAL_EXT_ZD 5'h05
`define SMC_MODE_SL_INT      5'h06
`define SMC_MODE_SL_INT_ZD   5'h08
`define SMC_MODE_SL_EXT      5'h0b
`define SMC_MODE_DIST        5'h10

`define SMC_PIN_LOW          2'h0
`define SMC_PIN_REF2_LOS     2'h1
`define SMC_PIN_REF2_SEL     2'h2
`define SMC_PIN_READBACK     2'h3

`define SMC_TYPE_IN          3'h0
`define SMC_TYPE_IN_PU       3'h1
`define SMC_TYPE_IN_PD       3'h2
`define SMC_TYPE_PP          3'h3
`define SMC_TYPE_PP_INV      3'h4
`define SMC_TYPE_OPEN_SRC    3'h5
`define SMC_TYPE_OPEN_DRN    3'h6

`define SMC_R10_RESET        32'h0000_000a
`define SMC_R11_RESET        32'h0400_000b

`define SMC_CLK_MHZ          25
`define SMC_SYNC_PULSE_NS    400
`define SMC_SYNC_PULSE_CYC   ((`SMC_SYNC_PULSE_NS * `SMC_CLK_MHZ + 999) / 1000)
`define SMC_PULSE_CNT_W      4

`endif

/* File: include/smc_pkg.sv */
// types shared by the sync and mode control block
package smc_pkg;

  typedef struct packed {
    logic first_loop_pd;
    logic second_loop_en;
    logic zero_delay;
    logic ext_vco;
    logic distribution;
    logic osc_as_ref;
    logic reserved_code;
  } smc_mode_s;

  typedef struct packed {
    logic out;
    logic oe;
    logic pull_up;
    logic pull_down;
  } smc_pin_s;

  typedef struct packed {
    logic clk;
    logic data;
    logic le;
  } smc_ser_s;

endpackage

/* File: src/smc_sync_mode_ctrl.sv */
// mode decode, feedback routing, sync generation and clock output gating
//
// Function
// - zero-delay: feedback select routes even output or external feedback to first loop
// - five-bit mode field decodes eight modes, others reserved
// - single-loop modes power down first loop, oscillator input is reference
// - distribution: reference one to outputs 0-11, oscillator to osc out, optional 6-9
// - sync operates only while sync enable is set, default enabled
// - sync enable rising generates sync on non-excluded groups
// - six exclude bits keep output pairs running through sync
// - digital delay loads only on sync, excluded groups ignore it
// - setting exclude never disturbs already synchronized outputs
// - sync holds non-excluded outputs low, release resumes toggling
// - sync pin output select: low, ref two los, ref two selected, readback
// - type 3 drives active high, type 4 drives inverted
// - three-bit pin type: three input kinds, four output kinds
// - qualify times sync edges to feedback-selected running output
// - polarity bit sets input sync level, toggling it makes a sync
// - auto sync on delay register writes at latch enable fall
// - pin as output forces internal sync input low, polarity asserts sync
// - crystal amplifier enable drives oscillator feedback amplifier
`timescale 1ns/1ps
`include "smc_regs.svh"

module smc_sync_mode_ctrl (
  input  wire logic              i_mclk,
  input  wire logic              i_rstn,
  input  wire smc_pkg::smc_ser_s i_ser,
  input  wire logic [11:0]       i_div_clk,
  input  wire logic              i_fb_ext_clk,
  input  wire logic              i_ref1_clk,
  input  wire logic              i_osc_clk,
  input  wire logic              i_dist_osc_to_6_9,
  input  wire logic              i_ref2_los,
  input  wire logic              i_ref2_selected,
  input  wire logic              i_sync_pin_in,
  output smc_pkg::smc_pin_s      o_sync_pin,
  output smc_pkg::smc_mode_s     o_mode,
  output logic                   o_fb_clk,
  output logic [6:0]             o_fb_route,
  output logic                   o_osc_amp_en,
  output logic                   o_osc_out0_clk,
  output logic [11:0]            o_clk_out,
  output logic [5:0]             o_grp_sync,
  output logic [5:0]             o_ddly_load
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic smc_pkg::smc_mode_s decode_mode(input logic [4:0] code);
    smc_pkg::smc_mode_s m;
    m = '0;
    unique case (code)
      `SMC_MODE_DUAL_INT:    m.second_loop_en = 1'b1;
      `SMC_MODE_DUAL_INT_ZD: begin
        m.second_loop_en = 1'b1;
        m.zero_delay     = 1'b1;
      end
      `SMC_MODE_DUAL_EXT: begin
        m.second_loop_en = 1'b1;
        m.ext_vco        = 1'b1;
      end
      `SMC_MODE_DUAL_EXT_ZD: begin
        m.second_loop_en = 1'b1;
        m.ext_vco        = 1'b1;
        m.zero_delay     = 1'b1;
      end
      `SMC_MODE_SL_INT, `SMC_MODE_SL_INT_ZD, `SMC_MODE_SL_EXT: begin
        m.first_loop_pd  = 1'b1;
        m.second_loop_en = 1'b1;
        m.osc_as_ref     = 1'b1;
        m.zero_delay     = (code == `SMC_MODE_SL_INT_ZD);
        m.ext_vco        = (code == `SMC_MODE_SL_EXT);
      end
      `SMC_MODE_DIST: begin
        m.first_loop_pd = 1'b1;
        m.distribution  = 1'b1;
      end
      default: begin
        m.first_loop_pd = 1'b1;
        m.reserved_code = 1'b1;
      end
    endcase
    return m;
  endfunction

  // picks the even output or the external feedback clock
  function automatic logic pick_fb(input logic [2:0] sel, input logic [11:0] clks, input logic ext);
    logic r;
    r = 1'b0;
    if (sel == `SMC_FB_EXT) begin
      r = ext;
    end else if (sel < `SMC_FB_EXT) begin
      r = clks[{sel, 1'b0}];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] r10_q;
  logic [31:0] r11_q;
  logic [31:0] shift_q;
  logic [31:0] rb_q;
  logic        ser_clk_q;
  logic        ser_le_q;
  logic        auto_pend_q;
  logic [`SMC_PULSE_CNT_W-1:0] pulse_cnt_q;
  logic        qclk_q;
  logic        sync_eff_q;
  logic [5:0]  grp_sync_q;
  logic [5:0]  sync_mask_q;

  wire logic       clk_rise = i_ser.clk & ~ser_clk_q;
  wire logic       le_rise  = i_ser.le & ~ser_le_q;
  wire logic       le_fall  = ~i_ser.le & ser_le_q;
  wire logic [4:0] wr_addr  = shift_q[`SMC_ADDR_W-1:0];

  wire logic [4:0] mode_code = r11_q[`SMC_MODE_HI:`SMC_MODE_LO];
  wire logic       en_sync   = r11_q[`SMC_EN_SYNC];
  wire logic [5:0] excl      = r11_q[`SMC_EXCL_HI:`SMC_EXCL_LO];
  wire logic [1:0] pin_sel   = r11_q[`SMC_PIN_SEL_HI:`SMC_PIN_SEL_LO];
  wire logic       qual      = r11_q[`SMC_QUAL];
  wire logic       pol       = r11_q[`SMC_POL];
  wire logic       auto_en   = r11_q[`SMC_AUTO];
  wire logic [2:0] pin_type  = r11_q[`SMC_TYPE_HI:`SMC_TYPE_LO];
  wire logic [2:0] fb_sel    = r10_q[`SMC_FB_SEL_HI:`SMC_FB_SEL_LO];

  ////////////////////////////////////////////////////////////////////////////
  // serial port: shift on clock rise, latch on latch enable rise
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      ser_clk_q <= 1'b0;
      ser_le_q  <= 1'b0;
    end else begin
      ser_clk_q <= i_ser.clk;
      ser_le_q  <= i_ser.le;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      shift_q <= 32'h0000_0000;
    end else if (clk_rise && !i_ser.le) begin
      shift_q <= {shift_q[30:0], i_ser.data};
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      r10_q <= `SMC_R10_RESET;
      r11_q <= `SMC_R11_RESET;
    end else if (le_rise) begin
      if (wr_addr == `SMC_ADDR_FB_DIV) begin
        r10_q <= shift_q;
      end
      if (wr_addr == `SMC_ADDR_MODE_SYNC) begin
        r11_q <= shift_q;
      end
    end
  end

  // readback of the addressed register, shifted out msb first
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      rb_q <= 32'h0000_0000;
    end else if (le_rise) begin
      rb_q <= (wr_addr == `SMC_ADDR_FB_DIV) ? r10_q :
              (wr_addr == `SMC_ADDR_MODE_SYNC) ? r11_q : 32'h0000_0000;
    end else if (clk_rise && !i_ser.le) begin
      rb_q <= {rb_q[30:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // internal sync pulses: enable rise and auto sync on delay writes
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      auto_pend_q <= 1'b0;
    end else if (le_rise) begin
      auto_pend_q <= auto_en && (wr_addr <= `SMC_ADDR_DLY_LAST);
    end else if (le_fall) begin
      auto_pend_q <= 1'b0;
    end
  end

  wire logic en_rise = le_rise && (wr_addr == `SMC_ADDR_MODE_SYNC) && !en_sync && shift_q[`SMC_EN_SYNC];

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      pulse_cnt_q <= '0;
    end else if (en_rise || (le_fall && auto_pend_q)) begin
      pulse_cnt_q <= `SMC_PULSE_CNT_W'(`SMC_SYNC_PULSE_CYC);
    end else if (pulse_cnt_q != '0) begin
      pulse_cnt_q <= pulse_cnt_q - `SMC_PULSE_CNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sync level: pin forced low when output, polarity applied
  wire logic pin_is_out = (pin_type >= `SMC_TYPE_PP) && (pin_type <= `SMC_TYPE_OPEN_DRN);
  wire logic pin_level  = pin_is_out ? 1'b0 : i_sync_pin_in;
  wire logic sync_raw   = en_sync && ((pin_level ^ pol) || (pulse_cnt_q != '0));
  wire logic qclk       = pick_fb(fb_sel, i_div_clk, i_fb_ext_clk);

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      qclk_q <= 1'b0;
    end else begin
      qclk_q <= qclk;
    end
  end

  // qualified sync moves only on a falling edge of the feedback output
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      sync_eff_q <= 1'b0;
    end else if (!qual || (qclk_q && !qclk)) begin
      sync_eff_q <= sync_raw;
    end
  end

  // group set taken while idle and frozen through the event, so a late
  // exclude write cannot release a pair early and skew it from its partners
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      sync_mask_q <= 6'h00;
    end else if (!sync_eff_q) begin
      sync_mask_q <= ~excl;
    end
  end

  wire logic [5:0] grp_sync_d = {6{sync_eff_q}} & sync_mask_q;

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      grp_sync_q <= 6'h00;
    end else begin
      grp_sync_q <= grp_sync_d;
    end
  end

  // delay values load as a group leaves sync
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      o_ddly_load <= 6'h00;
    end else begin
      o_ddly_load <= grp_sync_q & ~grp_sync_d;
    end
  end

  assign o_grp_sync = grp_sync_q;

  ////////////////////////////////////////////////////////////////////////////
  // clock outputs: source select then sync gating
  logic [11:0] clk_src;
  always_comb begin
    clk_src = i_div_clk;
    if (o_mode.distribution) begin
      clk_src = {12{i_ref1_clk}};
      if (i_dist_osc_to_6_9) begin
        clk_src[9:6] = {4{i_osc_clk}};
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 12; i++) begin
      o_clk_out[i] = clk_src[i] & ~grp_sync_q[i/2];
    end
  end

  assign o_osc_out0_clk = i_osc_clk;

  ////////////////////////////////////////////////////////////////////////////
  // mode, feedback route and oscillator amplifier
  wire smc_pkg::smc_mode_s mode_d = decode_mode(mode_code);

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      o_mode <= '0;
    end else begin
      o_mode <= mode_d;
    end
  end

  // route one-hot only for a defined select in a zero-delay mode
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      o_fb_route <= 7'h00;
    end else if (mode_d.zero_delay && fb_sel <= `SMC_FB_EXT) begin
      o_fb_route <= 7'h01 << fb_sel;
    end else begin
      o_fb_route <= 7'h00;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      o_osc_amp_en <= 1'b0;
    end else begin
      o_osc_amp_en <= r11_q[`SMC_XTAL_EN];
    end
  end

  assign o_fb_clk = o_mode.zero_delay ? qclk : 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // sync pin driver
  logic pin_val;
  always_comb begin
    unique case (pin_sel)
      `SMC_PIN_LOW:      pin_val = 1'b0;
      `SMC_PIN_REF2_LOS: pin_val = i_ref2_los;
      `SMC_PIN_REF2_SEL: pin_val = i_ref2_selected;
      `SMC_PIN_READBACK: pin_val = rb_q[31];
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      o_sync_pin <= '0;
    end else begin
      o_sync_pin <= '0;
      unique case (pin_type)
        `SMC_TYPE_IN_PU: o_sync_pin.pull_up <= 1'b1;
        `SMC_TYPE_IN_PD: o_sync_pin.pull_down <= 1'b1;
        `SMC_TYPE_PP: begin
          o_sync_pin.out <= pin_val;
          o_sync_pin.oe  <= 1'b1;
        end
        `SMC_TYPE_PP_INV: begin
          o_sync_pin.out <= ~pin_val;
          o_sync_pin.oe  <= 1'b1;
        end
        `SMC_TYPE_OPEN_SRC: begin
          o_sync_pin.out <= 1'b1;
          o_sync_pin.oe  <= pin_val;
        end
        `SMC_TYPE_OPEN_DRN: begin
          o_sync_pin.out <= 1'b0;
          o_sync_pin.oe  <= ~pin_val;
        end
        default: o_sync_pin <= '0;
      endcase
    end
  end

endmodule

/* File: verif/smc_host.sv */
// host model on the serial programming port
`timescale 1ns/1ps
module smc_host (
  input  wire logic         i_mclk,
  output smc_pkg::smc_ser_s o_ser
);
  initial o_ser = '0;
  // word goes out bit 31 first, each level held two cycles
  task automatic send(input logic [31:0] w);
    @(posedge i_mclk);
    for (int i = 31; i >= 0; i--) begin
      o_ser <= {1'b0, w[i], 1'b0};
      repeat (2) @(posedge i_mclk);
      o_ser.clk <= 1'b1;
      repeat (2) @(posedge i_mclk);
    end
    // serial clock parks low, released data line flips
    o_ser <= {1'b0, ~w[0], 1'b1};
    repeat (2) @(posedge i_mclk);
    o_ser.le <= 1'b0;
    repeat (2) @(posedge i_mclk);
  endtask
endmodule

/* File: verif/smc_checker.sv */
// assertions on the sync and mode control ports
`timescale 1ns/1ps
module smc_checker (
  input wire logic               i_mclk,
  input wire logic               i_rstn,
  input wire logic [11:0]        i_div_clk,
  input wire logic               i_fb_ext_clk,
  input wire logic               i_ref1_clk,
  input wire logic               i_osc_clk,
  input wire smc_pkg::smc_pin_s  o_sync_pin,
  input wire smc_pkg::smc_mode_s o_mode,
  input wire logic               o_fb_clk,
  input wire logic [6:0]         o_fb_route,
  input wire logic               o_osc_out0_clk,
  input wire logic [11:0]        o_clk_out,
  input wire logic [5:0]         o_grp_sync,
  input wire logic [5:0]         o_ddly_load
);
  logic [11:0] gate;
  always_comb for (int i = 0; i < 12; i++) gate[i] = i_div_clk[i] & ~o_grp_sync[i / 2];
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  sequence s_release;
    ($past(o_grp_sync) & ~o_grp_sync) != 6'h00;
  endsequence
  sequence s_load;
    ##[0:1] (o_ddly_load != 6'h00);
  endsequence
  // past values skip the cycle where the register moved ahead of o_mode
  AST_CLK_GATE: assert property (!$past(o_mode.distribution) && $stable(o_mode)
    |-> $past(o_clk_out) == $past(gate)) else $error("gated output wrong");
  AST_DIST: assert property ($past(o_mode.distribution) && $stable(o_mode) && $past(o_grp_sync) == 6'h00
    |-> $past(o_clk_out[5:0]) == {6{$past(i_ref1_clk)}}) else $error("distribution output wrong");
  AST_OSC_PASS: assert property (o_osc_out0_clk == i_osc_clk) else $error("osc out wrong");
  AST_FB_ONEHOT: assert property ($onehot0(o_fb_route)) else $error("route not one-hot");
  AST_FB_EXT: assert property ($past(o_fb_route[6]) && $stable(o_fb_route)
    |-> $past(o_fb_clk) == $past(i_fb_ext_clk)) else $error("ext feedback wrong");
  AST_DDLY_REL: assert property (s_release |-> s_load) else $error("no delay load");
  AST_DDLY_ONE: assert property (o_ddly_load != 6'h00 |=> o_ddly_load == 6'h00) else $error("load long");
  AST_PIN_KIND: assert property (o_sync_pin.oe |-> !o_sync_pin.pull_up && !o_sync_pin.pull_down)
    else $error("pull on output");
endmodule
bind smc_sync_mode_ctrl smc_checker u_chk (.i_mclk, .i_rstn, .i_div_clk, .i_fb_ext_clk, .i_ref1_clk, .i_osc_clk,
  .o_sync_pin, .o_mode, .o_fb_clk, .o_fb_route, .o_osc_out0_clk, .o_clk_out, .o_grp_sync, .o_ddly_load);

/* File: verif/tb_sync_and_mode_control.sv */
// self-checking bench for the sync and mode control block
`timescale 1ns/1ps
`include "smc_regs.svh"
module tb_sync_and_mode_control;
  logic clk = 1'b0, rstn = 1'b0, ext = 1'b0, r1 = 1'b0, osc = 1'b0, dsel = 1'b0;
  logic los = 1'b0, s2 = 1'b0, pin_in = 1'b0, fbc, amp, e;
  logic [11:0] div = 12'h000, cout;
  logic [6:0] route;
  logic frz = 1'b0, fbv = 1'b0;
  logic [5:0] grp, ex, seen = 6'h00;
  smc_pkg::smc_ser_s ser;
  smc_pkg::smc_pin_s pin;
  smc_pkg::smc_mode_s mode;
  int seed = 19, num_errors = 0, checked = 0, nsync = 0;
  int modes[$] = '{0, 2, 3, 5, 6, 8, 11, 16};
  smc_host host (.i_mclk(clk), .o_ser(ser));
  smc_sync_mode_ctrl dut (.i_mclk(clk), .i_rstn(rstn), .i_ser(ser), .i_div_clk(div), .i_fb_ext_clk(ext),
    .i_ref1_clk(r1), .i_osc_clk(osc), .i_dist_osc_to_6_9(dsel), .i_ref2_los(los), .i_ref2_selected(s2),
    .i_sync_pin_in(pin_in), .o_sync_pin(pin), .o_mode(mode), .o_fb_clk(fbc), .o_fb_route(route),
    .o_osc_amp_en(amp), .o_osc_out0_clk(), .o_clk_out(cout), .o_grp_sync(grp), .o_ddly_load());
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    div <= 12'($random(seed));
    {ext, r1, osc, dsel} <= {frz ? fbv : 1'($random(seed)), 3'($random(seed))};
    if (grp !== 6'h00) nsync++;
    seen <= seen | grp;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic logic [31:0] r11(input int md, en, x, ps, pol, au, ty, xt);
    return {5'(md), 1'(en), 6'(x), 2'(ps), 1'b0, 1'(pol), 1'(au), 3'(ty), 6'h00, 1'(xt), `SMC_ADDR_MODE_SYNC};
  endfunction
  function automatic logic [11:0] gate(input logic [11:0] d, input logic [5:0] g);
    for (int i = 0; i < 12; i++) d[i] = d[i] & ~g[i / 2];
    return d;
  endfunction
  function automatic logic [6:0] emode(input int m);
    logic sl, zd, xv;
    sl = m == 6 || m == 8 || m == 11;
    zd = m == 2 || m == 5 || m == 8;
    xv = m == 3 || m == 5 || m == 11;
    return {sl || m == 16, m != 16, zd, xv, m == 16, sl, 1'b0};
  endfunction
  task automatic wr(input logic [31:0] w);
    host.send(w);
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic pulse(input logic [31:0] w, input int n);
    nsync = 0;
    seen = 6'h00;
    wr(w);
    repeat (12) @(posedge clk);
    #1 chk("sync_cycles", nsync, n);
  endtask
  task automatic conclude;
    if (num_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("mode", mode, emode(0));
    chk("grp", grp, 0);
    chk("amp", amp, 0);
    foreach (modes[i]) begin
      wr(r11(modes[i], 1, 0, 0, 0, 0, 0, i % 2));
      chk("mode", mode, emode(modes[i]));
      chk("amp", amp, i % 2);
    end
    wr(r11(2, 1, 0, 0, 0, 0, 0, 0));
    for (int s = 0; s < 7; s++) begin
      wr({20'h00000, 1'b1, 3'h0, 3'(s), `SMC_ADDR_FB_DIV});
      chk("route", route, 7'h01 << s);
      chk("fb_clk", fbc, s == 6 ? ext : div[2 * s % 12]);
    end
    for (int k = 0; k < 3; k++) begin
      ex = 6'($random(seed));
      wr(r11(0, 1, ex, 0, 1, 0, 3, 0));
      chk("grp", grp, 6'(~ex));
      chk("clk_out", cout, gate(div, ~ex));
      wr(r11(0, 1, ex, 0, 0, 0, 3, 0));
      chk("grp", grp, 0);
    end
    // qualified sync: feedback input frozen so its falling edges are placed by hand
    frz = 1'b1;
    fbv = 1'b1;
    wr(r11(0, 1, 0, 0, 1, 0, 3, 0) | (32'h1 << `SMC_QUAL));
    chk("grp", grp, 0);
    fbv = 1'b0;
    repeat (4) @(posedge clk);
    #1 chk("grp", grp, 6'h3f);
    wr(r11(0, 1, 0, 0, 0, 0, 3, 0) | (32'h1 << `SMC_QUAL));
    chk("grp", grp, 6'h3f);
    fbv = 1'b1;
    repeat (2) @(posedge clk);
    #1 fbv = 1'b0;
    repeat (4) @(posedge clk);
    #1 chk("grp", grp, 0);
    frz = 1'b0;
    for (int t = 0; t < 7; t++)
      for (int p = 0; p < 4; p++) begin
        @(posedge clk) {los, s2} <= 2'($random(seed));
        wr(r11(0, 1, 63, p, 0, 0, t, 0));
        e = p == 1 ? los : p == 2 && s2;
        chk("pin_kind", {pin.oe, pin.pull_up, pin.pull_down},
          {t == 5 ? e : t == 6 ? !e : t > 2, t == 1, t == 2});
        chk("pin_out", pin.out, t == 3 ? e : t == 4 ? !e : t == 5);
      end
    wr(r11(0, 0, 0, 0, 0, 0, 0, 0));
    @(posedge clk) pin_in <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk("grp", grp, 0);
    @(posedge clk) pin_in <= 1'b0;
    pulse(r11(0, 1, 42, 0, 0, 0, 0, 0), `SMC_SYNC_PULSE_CYC);
    chk("seen", seen, 6'h15);
    @(posedge clk) pin_in <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk("grp", grp, 6'h15);
    wr(r11(0, 1, 42, 0, 1, 0, 0, 0));
    chk("grp", grp, 0);
    @(posedge clk) pin_in <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk("grp", grp, 6'h15);
    wr(r11(0, 1, 0, 0, 0, 1, 0, 0));
    pulse(32'h5a5a_5a43, `SMC_SYNC_PULSE_CYC);
    pulse(32'hffff_ffe7, 0);
    chk("amp", amp, 0);
    conclude();
  end
  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    conclude();
  end
endmodule
